//--- src/crc_pkg.sv
package crc_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [7:0] OFS_CTRL = 8'h00; // Control and pointer
    localparam logic [7:0] OFS_INPUT = 8'h01; // Byte input, write only
    localparam logic [7:0] OFS_WINDOW = 8'h02; // Result byte window
    localparam logic [7:0] OFS_FLIP = 8'h03; // Bit-reverse register

    // Control register field positions
    localparam int CTRL_PTR_LO = 0; // Result byte pointer, two bits
    localparam int CTRL_VAL_BIT = 2; // Init value select
    localparam int CTRL_INIT_BIT = 3; // Result init strobe
    localparam int CTRL_SEL_BIT = 4; // Poly width select

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [7:0] FLIP_RST = 8'h00;

    // Generator polynomials
    localparam logic [15:0] POLY16 = 16'h1021;
    localparam logic [31:0] POLY32 = 32'h04C1_1DB7;
    localparam logic [31:0] POLY32_REFL = 32'hEDB8_8320;

    // Initial result values
    localparam logic [31:0] INIT_ZEROS = 32'h0000_0000;
    localparam logic [31:0] INIT_ONES = 32'hFFFF_FFFF;

    // Bits folded per input write
    localparam int BITS_PER_BYTE = 8;

    // Register port request from software
    typedef struct packed {
        logic [7:0] addr; // Register offset
        logic [7:0] wdata; // Write data
        logic we; // Write strobe, one cycle
        logic re; // Read strobe, one cycle
    } reg_req_t;

endpackage

//--- src/crc_byte_step.sv
`timescale 1ns/100ps
module crc_byte_step
    import crc_pkg::*;
(
    input wire logic half_mode, // High for the 16-bit polynomial
    input wire logic [31:0] acc, // Current result
    input wire logic [7:0] data, // Input byte
    output logic [31:0] next_acc // Result after eight bits
);
    // One stage value per bit, stage 0 holds the folded byte
    logic [31:0] stage [0:BITS_PER_BYTE];

    // Fold the byte into the top or the low byte of the result
    always_comb begin
        if (half_mode) begin
            stage[0] = {acc[31:16], acc[15:0] ^ {data, 8'h00}};
        end else begin
            stage[0] = acc ^ {24'h00_0000, data};
        end
    end

    // Eight shift stages, all in one cycle so no start command is needed
    genvar i;
    generate
        for (i = 0; i < BITS_PER_BYTE; i++) begin : g_bit
            always_comb begin
                if (half_mode) begin
                    // MSB first, top bit tested before the shift
                    stage[i+1][31:16] = stage[i][31:16];
                    stage[i+1][15:0] = {stage[i][14:0], 1'b0} ^
                        (stage[i][15] ? POLY16 : 16'h0000);
                end else begin
                    // Reflected, low bit tested before the shift
                    stage[i+1] = {1'b0, stage[i][31:1]} ^
                        (stage[i][0] ? POLY32_REFL : 32'h0000_0000);
                end
            end
        end
    endgenerate

    assign next_acc = stage[BITS_PER_BYTE];

endmodule

//--- src/bit_flip.sv
`timescale 1ns/100ps
module bit_flip #(
    parameter int WIDTH = 8 // Width of the value to reverse
) (
    input wire logic [WIDTH-1:0] din, // Value as written
    output logic [WIDTH-1:0] dout // Value with bit order reversed
);
    // Pure wiring, costs no logic, so reads see it at once
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_rev
            assign dout[i] = din[WIDTH-1-i];
        end
    endgenerate

endmodule

//--- src/crc_engine_16_32.sv
// Summary of operation
// - Each written input byte is folded in
// - Result held as 16 or 32 bits
// - Result reached only through pointer and window
// - Separate bit-reverse register for data bytes
// - 16-bit mode: MSB first, polynomial 0x1021
// - 16-bit: byte XORed into upper eight bits
// - 16-bit: shift left, XOR poly on top bit
// - 32-bit mode: reflected 0x04C11DB7 polynomial
// - 32-bit: byte XORed into low byte
// - 32-bit: shift right, XOR on low bit
// - Width select: 0 is 32-bit, 1 16-bit
// - Init strobe loads zeros or ones per select
// - Pointer picks byte, aliases, increments per window access
// - Result updates after each input write
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module crc_engine_16_32
    import crc_pkg::*;
(
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input crc_pkg::reg_req_t req, // Register port request
    output logic [7:0] rdata // Read data, cycle after read strobe
);
    import crc_pkg::*;

    // Decoded accesses
    logic wr_ctrl; // Control write
    logic wr_input; // Input byte write
    logic wr_window; // Window write
    logic wr_flip; // Bit-reverse register write
    logic rd_window; // Window read

    // Control state
    logic half_mode_r; // Poly width select
    logic half_mode_nxt;
    logic init_ones_r; // Init value select
    logic init_ones_nxt;
    logic [1:0] ptr_r; // Result byte pointer
    logic [1:0] ptr_nxt;

    // Result and helper state
    logic [31:0] result_r; // Internal result, not mapped
    logic [31:0] result_nxt;
    logic [31:0] step_acc; // Result after folding one byte
    logic [7:0] flip_r; // Bit-reverse register
    logic [7:0] flip_nxt;
    logic [7:0] flip_rev; // Reversed view of flip_r
    logic [7:0] rdata_r; // Registered read data
    logic [7:0] rdata_nxt;

    // Effective byte select: aliasing folds the top half away
    logic [1:0] sel_byte;
    logic [7:0] win_byte; // Result byte under the pointer

    // Address decode; the master never raises both strobes together
    always_comb begin
        wr_ctrl = req.we && (req.addr == OFS_CTRL);
        wr_input = req.we && (req.addr == OFS_INPUT);
        wr_window = req.we && (req.addr == OFS_WINDOW);
        wr_flip = req.we && (req.addr == OFS_FLIP);
        rd_window = req.re && (req.addr == OFS_WINDOW);
    end

    // Folding network, eight bits in a single cycle
    crc_byte_step u_step (
        .half_mode(half_mode_r),
        .acc(result_r),
        .data(req.wdata),
        .next_acc(step_acc)
    );

    // Reverse network for the bit-reverse register
    bit_flip #(
        .WIDTH(8)
    ) u_flip (
        .din(flip_r),
        .dout(flip_rev)
    );

    // Byte selection under the pointer
    always_comb begin
        // In 16-bit mode pointer values 2 and 3 alias to 0 and 1
        sel_byte = half_mode_r ? {1'b0, ptr_r[0]} : ptr_r;
        case (sel_byte)
            2'h0: win_byte = result_r[7:0];
            2'h1: win_byte = result_r[15:8];
            2'h2: win_byte = result_r[23:16];
            2'h3: win_byte = result_r[31:24];
            default: win_byte = 8'h00;
        endcase
    end

    // Control next values
    always_comb begin
        half_mode_nxt = half_mode_r;
        init_ones_nxt = init_ones_r;
        ptr_nxt = ptr_r;
        if (wr_ctrl) begin
            // 0 picks the 32-bit polynomial, 1 the 16-bit one
            half_mode_nxt = req.wdata[CTRL_SEL_BIT];
            init_ones_nxt = req.wdata[CTRL_VAL_BIT];
            ptr_nxt = req.wdata[CTRL_PTR_LO +: 2];
        end else if (wr_window || rd_window) begin
            // Any window access moves to the next byte, wrapping
            ptr_nxt = ptr_r + 2'h1;
        end
    end

    // Control registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            half_mode_r <= CTRL_RST[CTRL_SEL_BIT];
            init_ones_r <= CTRL_RST[CTRL_VAL_BIT];
            ptr_r <= CTRL_RST[CTRL_PTR_LO +: 2];
        end else begin
            half_mode_r <= half_mode_nxt;
            init_ones_r <= init_ones_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    // Result next value
    always_comb begin
        result_nxt = result_r;
        if (wr_ctrl && req.wdata[CTRL_INIT_BIT]) begin
            // Init uses the select bit written in the same byte,
            // so one write can choose and load together
            result_nxt = req.wdata[CTRL_VAL_BIT] ?
                INIT_ONES : INIT_ZEROS;
        end else if (wr_input) begin
            // Automatic update, no start command
            // Mode steers the fold inside the step
            result_nxt = step_acc;
        end else if (wr_window) begin
            // Software may overwrite one byte of the result
            case (sel_byte)
                2'h0: result_nxt[7:0] = req.wdata;
                2'h1: result_nxt[15:8] = req.wdata;
                2'h2: result_nxt[23:16] = req.wdata;
                2'h3: result_nxt[31:24] = req.wdata;
                default: result_nxt = result_r;
            endcase
        end
    end

    // Result register; in 16-bit mode the upper half changes only on init
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            result_r <= RESULT_RST;
        end else begin
            result_r <= result_nxt;
        end
    end

    // Bit-reverse register, apart from the checksum path
    always_comb begin
        flip_nxt = wr_flip ? req.wdata : flip_r;
    end

    // Bit-reverse storage
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flip_r <= FLIP_RST;
        end else begin
            flip_r <= flip_nxt;
        end
    end

    // Read mux; data is zero outside the cycle after a read
    always_comb begin
        rdata_nxt = 8'h00;
        if (req.re) begin
            case (req.addr)
                // Init strobe always reads back as zero
                OFS_CTRL: rdata_nxt = {3'h0, half_mode_r, 1'b0,
                    init_ones_r, ptr_r};
                // Result visible only through the window
                OFS_WINDOW: rdata_nxt = win_byte;
                OFS_FLIP: rdata_nxt = flip_rev;
                // Input port and unmapped offsets read zero
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data register drives the output directly
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    // Checks on the behaviour above
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Init with the zero select clears every bit
    a_init_zero_load: assert property (
        (wr_ctrl && req.wdata[CTRL_INIT_BIT] && !req.wdata[CTRL_VAL_BIT])
        |=> (result_r == INIT_ZEROS))
        else $error("init did not load zeros");

    // Init with the ones select sets every bit
    a_init_ones_load: assert property (
        (wr_ctrl && req.wdata[CTRL_INIT_BIT] && req.wdata[CTRL_VAL_BIT])
        |=> (result_r == INIT_ONES))
        else $error("init did not load ones");

    // Pointer steps by one on each window access
    a_ptr_steps_once: assert property (
        (rd_window || wr_window) |=> (ptr_r == $past(ptr_r) + 2'h1))
        else $error("pointer did not increment");

    // Result moves only on init, input or window write
    a_result_holds_idle: assert property (
        !(wr_ctrl || wr_input || wr_window) |=> $stable(result_r))
        else $error("result changed without cause");

    // 16-bit fold never touches the upper half
    a_upper_half_kept: assert property (
        (wr_input && half_mode_r) |=> $stable(result_r[31:16]))
        else $error("upper half changed in 16-bit mode");

    // A zero byte on a zero 32-bit result stays zero
    a_zero_fold32: assert property (
        (wr_input && !half_mode_r && result_r == 32'h0000_0000 &&
        req.wdata == 8'h00) |=> (result_r == 32'h0000_0000))
        else $error("zero fold changed result");

    // Byte 0x80 on zero 16-bit result gives the known remainder
    sequence s_fold16_80;
        wr_input && half_mode_r && result_r[15:0] == 16'h0000 &&
        req.wdata == 8'h80;
    endsequence
    a_fold16_known: assert property (
        s_fold16_80 |=> (result_r[15:0] == 16'h9188))
        else $error("16-bit fold of 0x80 wrong");

    // Window read of byte 0 returns low result bits next cycle
    sequence s_rd_low;
        rd_window && sel_byte == 2'h0;
    endsequence
    a_window_low_byte: assert property (
        s_rd_low |=> (rdata == $past(result_r[7:0])))
        else $error("window read wrong byte");

    // Bit-reverse read returns the stored byte mirrored
    a_flip_mirrors: assert property (
        (req.re && req.addr == OFS_FLIP) |=>
        (rdata[0] == $past(flip_r[7]) && rdata[7] == $past(flip_r[0])))
        else $error("bit reverse read wrong");

    // Read data is zero when no read was made
    a_rdata_idle_zero: assert property (
        !req.re |=> (rdata == 8'h00))
        else $error("read data not zero when idle");

    // Control write loads the width select as written
    a_width_sel_load: assert property (
        wr_ctrl |=> (half_mode_r == $past(req.wdata[CTRL_SEL_BIT])))
        else $error("width select not loaded");

    // Control write loads the pointer from its low bits
    a_ptr_ctrl_load: assert property (
        wr_ctrl |=> (ptr_r == $past(req.wdata[CTRL_PTR_LO +: 2])))
        else $error("pointer not loaded");

    // Upper pointer values in 16-bit mode fall back on the low half
    sequence s_rd_alias;
        rd_window && half_mode_r && ptr_r[1];
    endsequence
    a_window_alias: assert property (
        s_rd_alias |=> (rdata == ($past(ptr_r[0]) ?
            $past(result_r[15:8]) : $past(result_r[7:0]))))
        else $error("aliased window read wrong byte");

    // Known vector: 0x63 on an all-ones 32-bit result
    a_fold32_table: assert property (
        (wr_input && !half_mode_r && result_r == INIT_ONES &&
        req.wdata == 8'h63) |=> (result_r == 32'hF946_2090))
        else $error("32-bit fold of 0x63 wrong");

    // Known vector: 0x63 on an all-ones 16-bit result
    a_fold16_table: assert property (
        (wr_input && half_mode_r && result_r[15:0] == 16'hFFFF &&
        req.wdata == 8'h63) |=> (result_r[15:0] == 16'hBD35))
        else $error("16-bit fold of 0x63 wrong");

    // Byte 0x01 on a zero 32-bit result gives the first remainder
    a_fold32_one: assert property (
        (wr_input && !half_mode_r && result_r == 32'h0000_0000 &&
        req.wdata == 8'h01) |=> (result_r == 32'h7707_3096))
        else $error("32-bit fold of 0x01 wrong");

    // Bit-reverse register keeps its byte between writes
    a_flip_holds: assert property (
        !wr_flip |=> $stable(flip_r))
        else $error("bit reverse register changed");

    // Input port reads back as zero
    a_input_reads_zero: assert property (
        (req.re && req.addr == OFS_INPUT) |=> (rdata == 8'h00))
        else $error("input port read not zero");

endmodule

//--- dv/tb_crc_engine_16_32.sv
`timescale 1ns/100ps
module tb_crc_engine_16_32;
    import crc_pkg::*;

    logic core_clk = 1'b0; // Bench clock, 100 MHz
    logic rst_b = 1'b0; // Held low through the first cycles
    crc_pkg::reg_req_t req = '0; // Register port request
    logic [7:0] rdata; // Read data from the block
    int n_fail = 0; // Mismatches seen
    int n_checks = 0; // Comparisons made
    logic [31:0] res_m = 32'h0000_0000; // Model of the running result
    logic sel_m = 1'b0; // Model of the width select

    crc_engine_16_32 u_dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .req(req),
        .rdata(rdata)
    );

    // Free-running clock, 10 ns period
    always #5 core_clk = ~core_clk;

    // Independent model of one 16-bit byte fold, MSB first
    function automatic logic [15:0] step16(input logic [15:0] a,
                                           input logic [7:0] d);
        a = a ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            a = a[15] ? ((a << 1) ^ POLY16) : (a << 1);
        end
        return a;
    endfunction

    // Independent model of one reflected 32-bit byte fold
    function automatic logic [31:0] step32(input logic [31:0] a,
                                           input logic [7:0] d);
        a = a ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            a = a[0] ? ((a >> 1) ^ POLY32_REFL) : (a >> 1);
        end
        return a;
    endfunction

    // Compare one byte and count it
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle write strobe, then an idle cycle so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= {a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        req <= '0;
        @(posedge core_clk);
    endtask

    // One-cycle read strobe; data is looked at in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input string nm);
        req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        req <= '0;
        #1 check(nm, rdata, exp);
        @(posedge core_clk);
    endtask

    // Control write that keeps the model in step
    task automatic set_ctrl(input logic [7:0] v);
        wr(OFS_CTRL, v);
        sel_m = v[CTRL_SEL_BIT];
        if (v[CTRL_INIT_BIT]) begin
            res_m = v[CTRL_VAL_BIT] ? INIT_ONES : INIT_ZEROS;
        end
    endtask

    // Feed one byte to the input port and fold it into the model
    task automatic feed(input logic [7:0] d);
        wr(OFS_INPUT, d);
        if (sel_m) begin
            res_m[15:0] = step16(res_m[15:0], d);
        end else begin
            res_m = step32(res_m, d);
        end
    endtask

    // Read the result through the window from byte 0, four accesses
    task automatic chk_res();
        set_ctrl({3'b000, sel_m, 4'h0});
        for (int i = 0; i < 4; i++) begin
            rd(OFS_WINDOW, sel_m ? res_m[8*(i%2)+:8] : res_m[8*i+:8],
               "result byte");
        end
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        // Reset state: control, flip and result all zero
        rd(OFS_CTRL, CTRL_RST, "ctrl reset");
        rd(OFS_FLIP, FLIP_RST, "flip reset");
        chk_res();
        // Bit reverse with asymmetric patterns
        wr(OFS_FLIP, 8'hF0);
        rd(OFS_FLIP, 8'h0F, "flip F0");
        wr(OFS_FLIP, 8'h01);
        rd(OFS_FLIP, 8'h80, "flip 01");
        wr(OFS_FLIP, 8'h3A);
        rd(OFS_FLIP, 8'h5C, "flip 3A");
        // Init to ones in 32-bit mode; pointer wraps back to 0
        set_ctrl(8'h0C);
        chk_res();
        rd(OFS_CTRL, 8'h00, "ctrl after wrap");
        // 32-bit stream from ones, then from zeros
        feed(8'hAA);
        feed(8'hBB);
        feed(8'hCC);
        chk_res();
        set_ctrl(8'h0C);
        feed(8'h63);
        chk_res();
        set_ctrl(8'h08);
        feed(8'h00);
        feed(8'h01);
        chk_res();
        set_ctrl(8'h08);
        feed(8'h63);
        chk_res();
        // 16-bit mode from zeros and from ones, aliased pointer
        set_ctrl(8'h18);
        feed(8'h63);
        chk_res();
        set_ctrl(8'h18);
        feed(8'h80);
        chk_res();
        set_ctrl(8'h1C);
        feed(8'h63);
        chk_res();
        set_ctrl(8'h1C);
        feed(8'h00);
        feed(8'h8C);
        feed(8'h7D);
        chk_res();
        rd(OFS_CTRL, 8'h10, "ctrl 16 wrap");
        // Window writes in 32-bit mode, then start at byte 2
        set_ctrl(8'h00);
        wr(OFS_WINDOW, 8'h11);
        wr(OFS_WINDOW, 8'h22);
        wr(OFS_WINDOW, 8'h33);
        wr(OFS_WINDOW, 8'h44);
        res_m = 32'h4433_2211;
        set_ctrl(8'h02);
        rd(OFS_WINDOW, 8'h33, "ptr 2");
        rd(OFS_WINDOW, 8'h44, "ptr 3");
        rd(OFS_WINDOW, 8'h11, "ptr wrap");
        feed(8'h5A);
        chk_res();
        // Input port and unmapped places read as zero, unmapped write ignored
        rd(OFS_INPUT, 8'h00, "input read");
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00, "unmapped read");
        chk_res();
        // Fold then immediate window read, no gap between strobes
        req <= {OFS_INPUT, 8'hC3, 1'b1, 1'b0};
        res_m = step32(res_m, 8'hC3);
        @(posedge core_clk);
        req <= {OFS_WINDOW, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        req <= '0;
        #1 check("fold in one clock", rdata, res_m[7:0]);
        @(posedge core_clk);
        #1 check("rdata one cycle", rdata, 8'h00);
        @(posedge core_clk);
        report_and_stop();
    end

endmodule
